/* File: pkg/io_processor_cfg.svh */
// Constants for the io_processor low-range opcode decoder.
// Assumes it is included by its bare name from the design files.
`ifndef IO_PROCESSOR_CFG_SVH
`define IO_PROCESSOR_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Widths
`define OPDEC_WORD_W      16
`define OPDEC_SHORT_W     6
`define OPDEC_OPC_W       7

////////////////////////////////////////////////////////////////////////////////
// Opcode groups, taken from opcode bits 6:2
`define GRP_MISC          5'h00
`define GRP_SHIFT         5'h01
`define GRP_IMM           5'h02
`define GRP_LONG          5'h03
`define GRP_REG           5'h04
`define GRP_STORE         5'h05
`define GRP_MEM           5'h06

////////////////////////////////////////////////////////////////////////////////
// Sub-operations, taken from opcode bits 1:0
`define SUB_PASS          2'h0
`define SUB_EXIT          2'h1
`define SUB_INT_OFF       2'h2
`define SUB_INT_ON        2'h3
`define SUB_SHR_END       2'h0
`define SUB_SHL_END       2'h1
`define SUB_SHR_CIRC      2'h2
`define SUB_SHL_CIRC      2'h3
`define SUB_LOAD          2'h0
`define SUB_AND           2'h1
`define SUB_ADD           2'h2
`define SUB_SUB           2'h3

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_ACC           16'h0000
`define RST_PC            16'h0000
`define RST_CARRY         1'h0
`define RST_INT_EN        1'h0

`endif

/* File: pkg/io_processor_pkg.sv */
// Types for the io_processor low-range opcode decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package io_processor_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEM  = 2'b01
    } exec_state_t;

endpackage

/* File: rtl/io_processor_op_decoder.sv */
// Decode and execute of io_processor opcodes 000 to 033 octal.
// Assumes an operand register file with combinational read on the same clock
// and a local memory that answers a held request with a one-cycle ack.
`include "io_processor_cfg.svh"

// Notes on behaviour
// - 004..007 shift carry and accumulator by short count, end-off or circular.
// - 010..013 load, AND, add, subtract the short field into the accumulator.
// - 014..017 load, AND, add, subtract the long constant into the accumulator.
// - 020..023 load, AND, add, subtract the selected operand register.
// - 024 stores the accumulator into the selected operand register.
// - 025 writes accumulator plus selected operand register back to that register.
// - 026 copies register to accumulator plus one, writes it back.
// - 027 copies register to accumulator minus one, writes it back.
// - 030 loads the memory word addressed by the selected operand register.
// - 031 ANDs the addressed memory word into the accumulator.
// - 032 adds the addressed memory word to the accumulator.
// - 033 subtracts the addressed memory word from the accumulator.
module io_processor_op_decoder #(
    parameter int WORD_W  = `OPDEC_WORD_W,
    parameter int SHORT_W = `OPDEC_SHORT_W
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset_n,
    // Instruction
    input  wire logic                 i_instr_valid,
    input  wire logic [`OPDEC_OPC_W-1:0] i_opcode,
    input  wire logic [SHORT_W-1:0]   i_instr_d,
    input  wire logic [WORD_W-1:0]    i_instr_k,
    input  wire logic [WORD_W-1:0]    i_return_addr,
    output logic                      o_instr_ready,
    output logic                      o_done,
    output logic                      o_illegal,
    // Operand register file
    output logic [SHORT_W-1:0]        o_opreg_raddr,
    input  wire logic [WORD_W-1:0]    i_opreg_rdata,
    output logic                      o_opreg_we,
    output logic [SHORT_W-1:0]        o_opreg_waddr,
    output logic [WORD_W-1:0]         o_opreg_wdata,
    // Local memory
    output logic                      o_mem_req,
    output logic [WORD_W-1:0]         o_mem_addr,
    input  wire logic                 i_mem_ack,
    input  wire logic [WORD_W-1:0]    i_mem_rdata,
    // Processor state
    output logic [WORD_W-1:0]         o_acc,
    output logic                      o_carry,
    output logic [WORD_W-1:0]         o_pc,
    output logic                      o_int_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (WORD_W < 2 || WORD_W > 64) begin : g_bad_word
        $error("WORD_W out of range");
    end
    if (SHORT_W < 1 || SHORT_W > WORD_W) begin : g_bad_short
        $error("SHORT_W out of range");
    end
    if (`OPDEC_OPC_W != 7) begin : g_bad_opc
        $error("Opcode width must be 7 for the group and sub-operation split");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        io_processor_pkg::exec_state_t state;
        logic [WORD_W-1:0]             acc;
        logic                          carry;
        logic [WORD_W-1:0]             pc;
        logic                          int_en;
        logic                          done;
        logic                          illegal;
        logic                          mem_req;
        logic [WORD_W-1:0]             mem_addr;
        logic [1:0]                    func;
        logic                          wr_en;
        logic [SHORT_W-1:0]            wr_addr;
        logic [WORD_W-1:0]             wr_data;
    } dec_state_t;

    dec_state_t s_r;
    dec_state_t s_nxt;
    logic       rst_meta_r;
    logic       rst_sync_n_r;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    // Every state flop then leaves reset on one edge, clear of the pin's timing
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_r   <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r   <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath helpers
    function automatic logic [WORD_W-1:0] alu(input logic [1:0]        f,
                                              input logic [WORD_W-1:0] a,
                                              input logic [WORD_W-1:0] b);
        logic [WORD_W-1:0] r;
        r = b;
        case (f)
            `SUB_LOAD: r = b;
            `SUB_AND:  r = a & b;
            `SUB_ADD:  r = a + b;
            `SUB_SUB:  r = a - b;
            default:   r = b;
        endcase
        return r;
    endfunction

    // Carry sits above the accumulator, so the shifted vector is one bit wider;
    // end-off counts past the vector clear it, circular counts wrap modulo its width
    function automatic logic [WORD_W:0] shift(input logic [1:0]         f,
                                              input logic [WORD_W:0]    v,
                                              input logic [SHORT_W-1:0] n);
        logic [2*WORD_W+1:0] dbl;
        logic [WORD_W:0]     r;
        int                  rot;
        dbl = {v, v};
        rot = int'(n) % (WORD_W + 1);
        r   = v;
        case (f)
            `SUB_SHR_END: begin
                r = v >> n;
            end
            `SUB_SHL_END: begin
                r = v << n;
            end
            `SUB_SHR_CIRC: begin
                dbl = dbl >> rot;
                r   = dbl[WORD_W:0];
            end
            `SUB_SHL_CIRC: begin
                dbl = dbl << rot;
                r   = dbl[2*WORD_W+1:WORD_W+1];
            end
            default: begin
                r = v;
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic [4:0]        grp;
    logic [1:0]        sub;
    logic [WORD_W-1:0] d_ext;
    logic              take;
    logic              mem_done;

    assign grp   = i_opcode[6:2];
    assign sub   = i_opcode[1:0];
    assign d_ext = WORD_W'(i_instr_d);
    // A pending register write blocks the next read of a possibly stale value
    assign take  = i_instr_valid && (s_r.state == io_processor_pkg::ST_IDLE) && !s_r.wr_en;
    // An ack outside a request is ignored
    assign mem_done = (s_r.state == io_processor_pkg::ST_MEM) && i_mem_ack;

    ////////////////////////////////////////////////////////////////////////////
    // Operand select for the accumulator groups
    logic [WORD_W-1:0] opd;
    logic [WORD_W-1:0] reg_inc;
    logic [WORD_W-1:0] reg_dec;

    // One operand mux feeds the accumulator function for the three direct groups
    always_comb begin
        case (grp)
            `GRP_IMM:  opd = d_ext;
            `GRP_LONG: opd = i_instr_k;
            default:   opd = i_opreg_rdata;
        endcase
    end

    // Steps wrap modulo the word width, like the adder
    assign reg_inc = i_opreg_rdata + WORD_W'(1);
    assign reg_dec = i_opreg_rdata - WORD_W'(1);

    always_comb begin
        s_nxt         = s_r;
        s_nxt.done    = 1'b0;
        s_nxt.illegal = 1'b0;
        s_nxt.wr_en   = 1'b0;
        case (s_r.state)
            io_processor_pkg::ST_IDLE: begin
                if (take) begin
                    s_nxt.pc   = s_r.pc + WORD_W'(1);
                    s_nxt.done = 1'b1;
                    case (grp)
                        `GRP_MISC: begin
                            case (sub)
                                `SUB_EXIT:    s_nxt.pc     = i_return_addr;
                                `SUB_INT_OFF: s_nxt.int_en = 1'b0;
                                `SUB_INT_ON:  s_nxt.int_en = 1'b1;
                                default:      s_nxt.int_en = s_r.int_en;
                            endcase
                        end
                        `GRP_SHIFT: begin
                            {s_nxt.carry, s_nxt.acc} = shift(sub, {s_r.carry, s_r.acc}, i_instr_d);
                        end
                        `GRP_IMM: begin
                            s_nxt.acc = alu(sub, s_r.acc, opd);
                        end
                        `GRP_LONG: begin
                            s_nxt.acc = alu(sub, s_r.acc, opd);
                        end
                        `GRP_REG: begin
                            s_nxt.acc = alu(sub, s_r.acc, opd);
                        end
                        `GRP_STORE: begin
                            // The write lands next cycle; ready stays low meanwhile
                            s_nxt.wr_en   = 1'b1;
                            s_nxt.wr_addr = i_instr_d;
                            case (sub)
                                2'h0: s_nxt.wr_data = s_r.acc;
                                2'h1: s_nxt.wr_data = s_r.acc + i_opreg_rdata;
                                2'h2: begin
                                    s_nxt.acc     = reg_inc;
                                    s_nxt.wr_data = reg_inc;
                                end
                                default: begin
                                    s_nxt.acc     = reg_dec;
                                    s_nxt.wr_data = reg_dec;
                                end
                            endcase
                        end
                        `GRP_MEM: begin
                            // Address comes from the register read at acceptance
                            s_nxt.state    = io_processor_pkg::ST_MEM;
                            s_nxt.mem_req  = 1'b1;
                            s_nxt.mem_addr = i_opreg_rdata;
                            s_nxt.func     = sub;
                            s_nxt.done     = 1'b0;
                        end
                        default: begin
                            // Higher opcodes belong to other decoders
                            // Flag only: no completion pulse, so the two never show together
                            s_nxt.illegal = 1'b1;
                            s_nxt.done    = 1'b0;
                        end
                    endcase
                end
            end
            io_processor_pkg::ST_MEM: begin
                // Request and address stay put until the ack edge
                if (mem_done) begin
                    s_nxt.mem_req = 1'b0;
                    s_nxt.acc     = alu(s_r.func, s_r.acc, i_mem_rdata);
                    s_nxt.done    = 1'b1;
                    s_nxt.state   = io_processor_pkg::ST_IDLE;
                end
            end
            default: begin
                s_nxt.state   = io_processor_pkg::ST_IDLE;
                s_nxt.mem_req = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            s_r        <= '0;
            s_r.acc    <= WORD_W'(`RST_ACC);
            s_r.pc     <= WORD_W'(`RST_PC);
            s_r.carry  <= `RST_CARRY;
            s_r.int_en <= `RST_INT_EN;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Instruction handshake
    assign o_instr_ready = (s_r.state == io_processor_pkg::ST_IDLE) && !s_r.wr_en;
    assign o_done        = s_r.done;
    assign o_illegal     = s_r.illegal;

    // Operand register file; the read address follows the short field directly
    assign o_opreg_raddr = i_instr_d;
    assign o_opreg_we    = s_r.wr_en;
    assign o_opreg_waddr = s_r.wr_addr;
    assign o_opreg_wdata = s_r.wr_data;

    // Local memory
    assign o_mem_req     = s_r.mem_req;
    assign o_mem_addr    = s_r.mem_addr;

    // Processor state
    assign o_acc         = s_r.acc;
    assign o_carry       = s_r.carry;
    assign o_pc          = s_r.pc;
    assign o_int_enable  = s_r.int_en;

endmodule

/* File: test/io_processor_op_decoder_sva.sv */
// Checker for io_processor_op_decoder, bound to its ports.
// Assumes the single clock and async low reset of the block.
module io_processor_op_decoder_sva #(
    parameter int WORD_W  = 16,
    parameter int SHORT_W = 6
) (
    // Clock, reset, instruction
    input wire logic               i_clk,
    input wire logic               i_reset_n,
    input wire logic               i_instr_valid,
    input wire logic [6:0]         i_opcode,
    input wire logic [SHORT_W-1:0] i_instr_d,
    input wire logic [WORD_W-1:0]  i_return_addr,
    input wire logic               o_instr_ready,
    input wire logic               o_done,
    input wire logic               o_illegal,
    // Register file and memory
    input wire logic [WORD_W-1:0]  i_opreg_rdata,
    input wire logic               o_opreg_we,
    input wire logic [SHORT_W-1:0] o_opreg_waddr,
    input wire logic [WORD_W-1:0]  o_opreg_wdata,
    input wire logic               o_mem_req,
    input wire logic [WORD_W-1:0]  o_mem_addr,
    input wire logic               i_mem_ack,
    // State
    input wire logic [WORD_W-1:0]  o_acc,
    input wire logic [WORD_W-1:0]  o_pc,
    input wire logic               o_int_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic tk;
    assign tk = i_instr_valid && o_instr_ready;
    ////////////////////////////////////////
    property p_step;
        tk && i_opcode[6:2] != 5'h06 |=> (o_done ^ o_illegal) && o_illegal == ($past(i_opcode) >= 7'h1c);
    endproperty
    a_step: assert property (p_step) else $error("bad completion pulse");
    property p_pc;
        tk && i_opcode[6:2] != 5'h06 |=> o_pc == ($past(i_opcode) == 7'h01 ? $past(i_return_addr) : $past(o_pc) + 1'b1);
    endproperty
    a_pc: assert property (p_pc) else $error("bad program address");
    property p_int;
        tk && i_opcode[6:1] == 6'h01 |=> o_int_enable == $past(i_opcode[0]);
    endproperty
    a_int: assert property (p_int) else $error("bad interrupt enable");
    property p_memreq;
        tk && i_opcode[6:2] == 5'h06 |=> o_mem_req && !o_done && o_mem_addr == $past(i_opreg_rdata);
    endproperty
    a_memreq: assert property (p_memreq) else $error("bad memory request");
    property p_memhold;
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr);
    endproperty
    a_memhold: assert property (p_memhold) else $error("request dropped early");
    property p_memend;
        o_mem_req && i_mem_ack |=> !o_mem_req && o_done;
    endproperty
    a_memend: assert property (p_memend) else $error("memory op not closed");
    property p_store;
        tk && i_opcode == 7'h14 |=> o_opreg_waddr == $past(i_instr_d) && o_opreg_wdata == $past(o_acc) && $stable(o_acc);
    endproperty
    a_store: assert property (p_store) else $error("bad register store");
    property p_wpend;
        tk && i_opcode[6:2] == 5'h05 |=> o_opreg_we && !o_instr_ready ##1 !o_opreg_we && o_instr_ready;
    endproperty
    a_wpend: assert property (p_wpend) else $error("bad write strobe");
    property p_incdec;
        tk && i_opcode[6:1] == 6'h0b |=> o_acc == o_opreg_wdata
            && o_opreg_wdata == ($past(i_opcode[0]) ? $past(i_opreg_rdata) - 1'b1 : $past(i_opreg_rdata) + 1'b1);
    endproperty
    a_incdec: assert property (p_incdec) else $error("bad step of register");
endmodule

bind io_processor_op_decoder io_processor_op_decoder_sva #(.WORD_W(WORD_W), .SHORT_W(SHORT_W)) u_sva (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid), .i_opcode(i_opcode),
    .i_instr_d(i_instr_d), .i_return_addr(i_return_addr), .o_instr_ready(o_instr_ready), .o_done(o_done),
    .o_illegal(o_illegal), .i_opreg_rdata(i_opreg_rdata), .o_opreg_we(o_opreg_we),
    .o_opreg_waddr(o_opreg_waddr), .o_opreg_wdata(o_opreg_wdata), .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack), .o_acc(o_acc), .o_pc(o_pc), .o_int_enable(o_int_enable));

/* File: test/io_processor_op_decoder_tb_top.sv */
// Self-checking bench for io_processor_op_decoder.
// Assumes the bound checker and the register and memory model on the far side.
module io_processor_op_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, vld, done, ill, we, mreq, ack, carry, ie, rdy, r_c, r_ie;
    logic [6:0]  op;
    logic [5:0]  d, raddr, waddr;
    logic [15:0] k, ra, rdata, wdata, maddr, mdata, acc, pc, r_acc, r_pc;
    logic [15:0] r_reg [64];
    logic [5:0]  tab [4] = '{6'h00, 6'h10, 6'h11, 6'h3f};
    logic [34:0] sq [$];
    logic [21:0] wq [$];
    int          error_cnt, n_checks, seed, x;

    io_processor_op_decoder i_dut (
        .i_clk(clk), .i_reset_n(rst_n), .i_instr_valid(vld), .i_opcode(op), .i_instr_d(d),
        .i_instr_k(k), .i_return_addr(ra), .o_instr_ready(rdy), .o_done(done), .o_illegal(ill),
        .o_opreg_raddr(raddr), .i_opreg_rdata(rdata), .o_opreg_we(we), .o_opreg_waddr(waddr),
        .o_opreg_wdata(wdata), .o_mem_req(mreq), .o_mem_addr(maddr), .i_mem_ack(ack),
        .i_mem_rdata(mdata), .o_acc(acc), .o_carry(carry), .o_pc(pc), .o_int_enable(ie));
    opreg_mem_model i_model (
        .i_clk(clk), .i_raddr(raddr), .o_rdata(rdata), .i_we(we), .i_waddr(waddr), .i_wdata(wdata),
        .i_req(mreq), .i_addr(maddr), .o_ack(ack), .o_mdata(mdata));
    ////////////////////////////////////////
    function automatic logic [15:0] mem_word(input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ 16'ha5c3;
    endfunction
    task automatic chk_state(input logic [34:0] got, input logic [34:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: state got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_write(input logic [21:0] got, input logic [21:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: reg write got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic idle(input int n);
        #1 vld = 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // Drives one instruction, then notes what the state must become
    task automatic issue(input logic [6:0] o, input logic [5:0] sel, input logic [15:0] kk);
        logic [16:0] v;
        logic [15:0] opd, rv;
        int          i;
        #1 op = o;
        d = sel;
        k = kk;
        ra = 16'($random(seed));
        vld = 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (rdy === 1'b1) break;
        end
        if (i == 40) begin
            $display("mismatch at %0t: ready timeout", $time);
            error_cnt++;
            final_report();
        end
        @(posedge clk);
        rv = r_reg[sel];
        v = {r_c, r_acc};
        opd = o[4:2] == 3'h2 ? 16'(sel) : o[4:2] == 3'h3 ? kk : o[4:2] == 3'h4 ? rv : mem_word(rv);
        r_pc = o == 7'h01 ? ra : r_pc + 16'h0001;
        if (o < 7'h1c) case (o[4:2])
            3'h0: if (o[1]) r_ie = o[0];
            3'h1: begin
                case (o[1:0])
                    2'h0: v = v >> sel;
                    2'h1: v = v << sel;
                    2'h2: v = 17'({v, v} >> (sel % 17));
                    default: v = 17'(({v, v} << (sel % 17)) >> 17);
                endcase
                {r_c, r_acc} = v;
            end
            3'h5: begin
                if (o[1]) r_acc = o[0] ? rv - 16'h0001 : rv + 16'h0001;
                rv = (o[1:0] == 2'h1) ? r_acc + rv : r_acc;
                r_reg[sel] = rv;
                wq.push_back({sel, rv});
            end
            default: case (o[1:0])
                2'h0: r_acc = opd;
                2'h1: r_acc = r_acc & opd;
                2'h2: r_acc = r_acc + opd;
                default: r_acc = r_acc - opd;
            endcase
        endcase
        sq.push_back({o >= 7'h1c, r_acc, r_c, r_pc, r_ie});
    endtask
    ////////////////////////////////////////
    always @(negedge clk) begin
        if (done === 1'b1 || ill === 1'b1) chk_state({ill, acc, carry, pc, ie}, sq.pop_front());
        if (we === 1'b1) chk_write({waddr, wdata}, wq.pop_front());
    end
    initial forever #20 clk = ~clk;
    initial begin
        seed = 2597;
        {clk, rst_n, vld, op, d, k, ra} = '0;
        {r_acc, r_pc, r_c, r_ie, error_cnt, n_checks} = '0;
        for (int i = 0; i < 64; i++) r_reg[i] = 16'(i) * 16'h0a13 + 16'h0004;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 29; i++) issue(7'(i), 6'($random(seed)), 16'($random(seed)));
        for (int i = 0; i < 16; i++) begin
            issue(7'h0c, 6'h00, 16'($random(seed)));
            issue(7'h04 + 7'(i / 4), tab[i % 4], 16'h0000);
        end
        // Write then read of one register, back to back
        issue(7'h16, 6'h05, 16'h0000);
        issue(7'h10, 6'h05, 16'h0000);
        issue(7'h17, 6'h05, 16'h0000);
        issue(7'h1b, 6'h05, 16'h0000);
        for (int i = 0; i < 400; i++) begin
            x = $unsigned($random(seed)) % 30;
            issue(x == 29 ? 7'h7f : 7'(x), 6'($random(seed)), 16'($random(seed)));
            if (x[0]) idle(2);
        end
        idle(30);
        chk_state(35'(sq.size() + wq.size()), 35'h0);
        final_report();
    end
endmodule

/* File: test/opreg_mem_model.sv */
// Operand register file and local memory facing the decoder.
// Assumes the decoder clock; memory words in the ack cycle are a fixed function of address.
module opreg_mem_model (
    // Register file
    input  wire logic        i_clk,
    input  wire logic [5:0]  i_raddr,
    output logic      [15:0] o_rdata,
    input  wire logic        i_we,
    input  wire logic [5:0]  i_waddr,
    input  wire logic [15:0] i_wdata,
    // Memory
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    output logic             o_ack,
    output logic      [15:0] o_mdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] regs [64];
    logic [3:0]  cnt;
    initial begin
        for (int i = 0; i < 64; i++) regs[i] = 16'(i) * 16'h0a13 + 16'h0004;
        o_ack = 1'b0;
        cnt = 4'h0;
    end
    assign o_rdata = regs[i_raddr];
    // Word is altered outside the ack cycle, so a stale sample never matches
    assign o_mdata = {i_addr[7:0], i_addr[15:8]} ^ (o_ack ? 16'ha5c3 : 16'h5a3c);
    // Ack delay taken from address bits, prompt and slow alike
    always @(posedge i_clk) begin
        if (i_we) regs[i_waddr] <= i_wdata;
        o_ack <= i_req && !o_ack && cnt == {i_addr[1:0], 2'b00};
        cnt <= (i_req && !o_ack) ? cnt + 4'h1 : 4'h0;
    end
endmodule
